// [rtl/mcu_seq_pkg.sv]
// Constants shared by the sequencer core and its return stack.
// Assumes a single clock in which one edge is one instruction cycle.
package mcu_seq_pkg;

    // Program store geometry.
    localparam int ROM_WORDS      = 1024;
    localparam int PC_WIDTH       = 10;
    localparam int WORD_WIDTH     = 8;
    localparam int PAGE_COUNT     = 16;
    localparam int PAGE_WORDS     = 64;
    localparam int PAGE_LSB       = 6;

    // Data store geometry.
    localparam int RAM_DIGITS     = 64;
    localparam int RAM_REGISTERS  = 4;
    localparam int REG_DIGITS     = 16;
    localparam int DIGIT_WIDTH    = 4;
    localparam int POINTER_WIDTH  = 6;
    localparam int REG_SEL_WIDTH  = 2;

    // Reset values.
    localparam logic [9:0] PC_RESET      = 10'h000;
    localparam logic [5:0] POINTER_RESET = 6'h00;
    localparam logic [3:0] NIBBLE_RESET  = 4'h0;
    localparam logic [7:0] LATCH_RESET   = 8'h00;

    // Page that single-word subroutine calls enter.
    localparam logic [3:0] CALL_PAGE     = 4'h2;

    // Instruction group fields.
    localparam logic [1:0] GRP_JUMP_PAGE = 2'b11;
    localparam logic [1:0] GRP_CALL_PAGE = 2'b10;
    localparam logic [3:0] GRP_LOAD_IMM  = 4'h1;
    localparam logic [3:0] GRP_TWO_WORD  = 4'h2;
    localparam logic [5:0] GRP_LONG_JUMP = 6'h0A;
    localparam logic [5:0] GRP_LONG_CALL = 6'h0B;

    // Single-word opcodes.
    localparam logic [7:0] OP_NOP             = 8'h00;
    localparam logic [7:0] OP_RETURN          = 8'h01;
    localparam logic [7:0] OP_JUMP_INDIRECT   = 8'h02;
    localparam logic [7:0] OP_LATCH_INDIRECT  = 8'h03;
    localparam logic [7:0] OP_RAM_TO_ACC      = 8'h04;
    localparam logic [7:0] OP_ACC_TO_RAM      = 8'h05;
    localparam logic [7:0] OP_EXCHANGE_RAM    = 8'h06;
    localparam logic [7:0] OP_DIGIT_OUT       = 8'h07;
    localparam logic [7:0] OP_LATCH_FROM_RAM  = 8'h08;
    localparam logic [7:0] OP_RAM_FROM_LATCH  = 8'h09;
    localparam logic [7:0] OP_RAM_FROM_PORT   = 8'h0A;
    localparam logic [7:0] OP_INC_DIGIT_SKIP  = 8'h0B;
    localparam logic [7:0] OP_SKIP_ACC_ZERO   = 8'h0C;

    // Two-word opcodes; the second word is the operand.
    localparam logic [7:0] OP_LOAD_DIRECT_RAM = 8'h20;
    localparam logic [7:0] OP_XCHG_DIRECT_RAM = 8'h21;
    localparam logic [7:0] OP_LOAD_POINTER    = 8'h22;

    // Sequencer states.
    typedef enum logic [1:0]
    {
        FETCH_WORD   = 2'b01,
        OPERAND_WORD = 2'b10
    } seq_state_type;

endpackage : mcu_seq_pkg

// [rtl/mcu_sequencer.sv]
// Program sequencing and data-memory addressing of a 4-bit controller.
// Assumes one mclk edge per instruction cycle and a loaded program store.
//
// Behaviour
// - Program store holds 1024 eight-bit words.
// - Page jumps use 64-word pages, indirects 256-word pages.
// - Ten-bit program counter selects the word.
// - Program counter reloads every instruction cycle.
// - Non-transfer instructions advance counter by one.
// - Three ten-bit return levels form a stack.
// - Push shifts levels deeper, drops deepest.
// - Fetched words are decoded, executed, or skipped.
// - Data store: four registers of sixteen digits.
// - Six-bit RAM pointer selects data digits.
// - Upper pointer bits choose the data register.
// - Lower pointer bits choose the digit.
// - Digit moves to, from, exchanges with accumulator.
// - Digit loads latch, from latch, from port.
// - Direct RAM instructions address by operand.
// - Digit field drives the digit outputs.
// - Bits use positive logic throughout.
module mcu_sequencer
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       reset,
    // Program store loading port.
    input  wire logic       rom_load_en,
    input  wire logic [9:0] rom_load_addr,
    input  wire logic [7:0] rom_load_data,
    // Port lines read into a digit.
    input  wire logic [3:0] port_nibble_in,
    // Registered state and outputs.
    output logic      [9:0] program_counter,
    output logic      [5:0] ram_pointer,
    output logic      [3:0] accumulator,
    output logic      [7:0] latch_out,
    output logic      [3:0] digit_out
);

    // Stores.
    logic [7:0] rom [mcu_seq_pkg::ROM_WORDS];
    logic [3:0] ram [mcu_seq_pkg::RAM_DIGITS];

    // Sequencer state.
    mcu_seq_pkg::seq_state_type state_reg;
    mcu_seq_pkg::seq_state_type state_next;
    logic [9:0] pc_reg;
    logic [9:0] pc_next;
    logic [5:0] ptr_reg;
    logic [5:0] ptr_next;
    logic [3:0] acc_reg;
    logic [3:0] acc_next;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [3:0] digit_reg;
    logic [3:0] digit_next;
    logic [7:0] opcode_reg;
    logic [7:0] opcode_next;
    logic       skip_reg;
    logic       skip_next;

    // Combinational helpers.
    logic [7:0] fetched;
    logic [7:0] indirect_word;
    logic [9:0] pc_inc;
    logic [3:0] digit_inc;
    logic [5:0] ptr_addr;
    logic [5:0] direct_addr;
    logic [3:0] ptr_data;
    logic [3:0] direct_data;
    logic       ram_we;
    logic [5:0] ram_waddr;
    logic [3:0] ram_wdata;

    return_stack_if stk ();

    // Builds a data-store address from register and digit fields.
    function automatic logic [5:0] ram_index
    (
        input logic [1:0] reg_sel,
        input logic [3:0] digit_sel
    );
        ram_index = {reg_sel, digit_sel};
    endfunction

    // Tells whether an opcode carries an operand word.
    function automatic logic is_two_word(input logic [7:0] op);
        is_two_word = (op[7:4] == mcu_seq_pkg::GRP_TWO_WORD);
    endfunction

    // Store reads: current word, indirect word and both RAM addresses.
    always_comb
    begin
        fetched       = rom[pc_reg];
        ptr_addr      = ram_index(ptr_reg[5:4], ptr_reg[3:0]);
        ptr_data      = ram[ptr_addr];
        indirect_word = rom[{pc_reg[9:8], acc_reg, ptr_data}];
        direct_addr   = ram_index(fetched[5:4], fetched[3:0]);
        direct_data   = ram[direct_addr];
        pc_inc        = pc_reg + 10'h001;
        digit_inc     = ptr_reg[3:0] + 4'h1;
    end

    // Decode, execute and next-address selection.
    always_comb
    begin
        state_next    = mcu_seq_pkg::FETCH_WORD;
        pc_next       = pc_inc;
        ptr_next      = ptr_reg;
        acc_next      = acc_reg;
        latch_next    = latch_reg;
        digit_next    = digit_reg;
        opcode_next   = opcode_reg;
        skip_next     = skip_reg;
        ram_we        = 1'b0;
        ram_waddr     = ptr_addr;
        ram_wdata     = acc_reg;
        stk.push      = 1'b0;
        stk.pop       = 1'b0;
        stk.push_addr = pc_inc;
        case (state_reg)
            mcu_seq_pkg::FETCH_WORD:
            begin
                if (is_two_word(fetched))
                begin
                    // Skip flag is kept so the operand is passed too.
                    opcode_next = fetched;
                    state_next  = mcu_seq_pkg::OPERAND_WORD;
                end
                else if (skip_reg)
                begin
                    skip_next = 1'b0;
                end
                else if (fetched[7:6] == mcu_seq_pkg::GRP_JUMP_PAGE)
                begin
                    pc_next = {pc_reg[9:6], fetched[5:0]};
                end
                else if (fetched[7:6] == mcu_seq_pkg::GRP_CALL_PAGE)
                begin
                    stk.push = 1'b1;
                    pc_next  = {mcu_seq_pkg::CALL_PAGE, fetched[5:0]};
                end
                else if (fetched[7:4] == mcu_seq_pkg::GRP_LOAD_IMM)
                begin
                    acc_next = fetched[3:0];
                end
                else
                begin
                    case (fetched)
                        mcu_seq_pkg::OP_RETURN:
                        begin
                            stk.pop = 1'b1;
                            pc_next = stk.top;
                        end
                        mcu_seq_pkg::OP_JUMP_INDIRECT:
                        begin
                            pc_next = {pc_reg[9:8], indirect_word};
                        end
                        mcu_seq_pkg::OP_LATCH_INDIRECT:
                        begin
                            latch_next = indirect_word;
                        end
                        mcu_seq_pkg::OP_RAM_TO_ACC:
                        begin
                            acc_next = ptr_data;
                        end
                        mcu_seq_pkg::OP_ACC_TO_RAM:
                        begin
                            ram_we = 1'b1;
                        end
                        mcu_seq_pkg::OP_EXCHANGE_RAM:
                        begin
                            acc_next = ptr_data;
                            ram_we   = 1'b1;
                        end
                        mcu_seq_pkg::OP_DIGIT_OUT:
                        begin
                            digit_next = ptr_reg[3:0];
                        end
                        mcu_seq_pkg::OP_LATCH_FROM_RAM:
                        begin
                            latch_next = {acc_reg, ptr_data};
                        end
                        mcu_seq_pkg::OP_RAM_FROM_LATCH:
                        begin
                            ram_we    = 1'b1;
                            ram_wdata = latch_reg[3:0];
                        end
                        mcu_seq_pkg::OP_RAM_FROM_PORT:
                        begin
                            ram_we    = 1'b1;
                            ram_wdata = port_nibble_in;
                        end
                        mcu_seq_pkg::OP_INC_DIGIT_SKIP:
                        begin
                            ptr_next  = {ptr_reg[5:4], digit_inc};
                            skip_next = (digit_inc == 4'h0);
                        end
                        mcu_seq_pkg::OP_SKIP_ACC_ZERO:
                        begin
                            skip_next = (acc_reg == 4'h0);
                        end
                        default:
                        begin
                            // Unassigned codes behave as no operation.
                            skip_next = 1'b0;
                        end
                    endcase
                end
            end
            mcu_seq_pkg::OPERAND_WORD:
            begin
                skip_next = 1'b0;
                if (!skip_reg)
                begin
                    if (opcode_reg == mcu_seq_pkg::OP_LOAD_DIRECT_RAM)
                    begin
                        acc_next = direct_data;
                    end
                    else if (opcode_reg == mcu_seq_pkg::OP_XCHG_DIRECT_RAM)
                    begin
                        acc_next  = direct_data;
                        ram_we    = 1'b1;
                        ram_waddr = direct_addr;
                    end
                    else if (opcode_reg == mcu_seq_pkg::OP_LOAD_POINTER)
                    begin
                        ptr_next = fetched[5:0];
                    end
                    else if (opcode_reg[7:2] == mcu_seq_pkg::GRP_LONG_JUMP)
                    begin
                        pc_next = {opcode_reg[1:0], fetched};
                    end
                    else if (opcode_reg[7:2] == mcu_seq_pkg::GRP_LONG_CALL)
                    begin
                        stk.push = 1'b1;
                        pc_next  = {opcode_reg[1:0], fetched};
                    end
                end
            end
            default:
            begin
                state_next = mcu_seq_pkg::FETCH_WORD;
            end
        endcase
    end

    // Registers the sequencer state.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_reg  <= mcu_seq_pkg::FETCH_WORD;
            pc_reg     <= mcu_seq_pkg::PC_RESET;
            ptr_reg    <= mcu_seq_pkg::POINTER_RESET;
            acc_reg    <= mcu_seq_pkg::NIBBLE_RESET;
            latch_reg  <= mcu_seq_pkg::LATCH_RESET;
            digit_reg  <= mcu_seq_pkg::NIBBLE_RESET;
            opcode_reg <= mcu_seq_pkg::LATCH_RESET;
            skip_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            pc_reg     <= pc_next;
            ptr_reg    <= ptr_next;
            acc_reg    <= acc_next;
            latch_reg  <= latch_next;
            digit_reg  <= digit_next;
            opcode_reg <= opcode_next;
            skip_reg   <= skip_next;
        end
    end

    // Data store write port; contents are not cleared by reset.
    always_ff @(posedge mclk)
    begin
        if (ram_we && !reset)
        begin
            ram[ram_waddr] <= ram_wdata;
        end
    end

    // Program store loading port.
    always_ff @(posedge mclk)
    begin
        if (rom_load_en)
        begin
            rom[rom_load_addr] <= rom_load_data;
        end
    end

    return_stack u_stack
    (
        .mclk  (mclk),
        .reset (reset),
        .port  (stk.stack)
    );

    // Outputs come straight from registers, high meaning a set bit.
    assign program_counter = pc_reg;
    assign ram_pointer     = ptr_reg;
    assign accumulator     = acc_reg;
    assign latch_out       = latch_reg;
    assign digit_out       = digit_reg;

endmodule // mcu_sequencer

// [rtl/return_stack.sv]
// Three-level return address stack of the sequencer core.
// Assumes push and pop are never asserted in the same cycle.
module return_stack
(
    // Clock and reset.
    input  wire logic     mclk,
    input  wire logic     reset,
    // Link to the core.
    return_stack_if.stack port
);

    logic [9:0] return_stack_top_reg;
    logic [9:0] return_stack_mid_reg;
    logic [9:0] return_stack_bottom_reg;
    logic [9:0] return_stack_top_next;
    logic [9:0] return_stack_mid_next;
    logic [9:0] return_stack_bottom_next;

    // A push shifts deeper and drops the bottom; a pop shifts up.
    always_comb
    begin
        return_stack_top_next    = return_stack_top_reg;
        return_stack_mid_next    = return_stack_mid_reg;
        return_stack_bottom_next = return_stack_bottom_reg;
        if (port.push)
        begin
            return_stack_top_next    = port.push_addr;
            return_stack_mid_next    = return_stack_top_reg;
            return_stack_bottom_next = return_stack_mid_reg;
        end
        else if (port.pop)
        begin
            // The bottom level keeps its value when emptied.
            return_stack_top_next = return_stack_mid_reg;
            return_stack_mid_next = return_stack_bottom_reg;
        end
    end

    // Registers the three levels.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            return_stack_top_reg    <= mcu_seq_pkg::PC_RESET;
            return_stack_mid_reg    <= mcu_seq_pkg::PC_RESET;
            return_stack_bottom_reg <= mcu_seq_pkg::PC_RESET;
        end
        else
        begin
            return_stack_top_reg    <= return_stack_top_next;
            return_stack_mid_reg    <= return_stack_mid_next;
            return_stack_bottom_reg <= return_stack_bottom_next;
        end
    end

    assign port.top = return_stack_top_reg;

endmodule // return_stack

// [rtl/return_stack_if.sv]
// Carries push, pop and the top level between the core and its stack.
// Assumes both ends sit in the same clock domain.
interface return_stack_if;

    logic       push;
    logic       pop;
    logic [9:0] push_addr;
    logic [9:0] top;

    modport owner
    (
        output push,
        output pop,
        output push_addr,
        input  top
    );

    modport stack
    (
        input  push,
        input  pop,
        input  push_addr,
        output top
    );

endinterface : return_stack_if

// [verification/mcu_rom_sequencer_ram_addressing_test.sv]
// Self-checking bench for the sequencer core, with its checker bound.
// Assumes the program store is loaded while reset is held.
module mcu_rom_sequencer_ram_addressing_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {int cyc; int sel; logic [9:0] val;} note_type;

    logic       mclk           = 1'b0;
    logic       reset          = 1'b1;
    logic       rom_load_en    = 1'b0;
    logic [9:0] rom_load_addr  = 10'h000;
    logic [7:0] rom_load_data  = 8'h00;
    logic [3:0] port_nibble_in = 4'h0;
    logic [9:0] program_counter;
    logic [5:0] ram_pointer;
    logic [3:0] accumulator;
    logic [7:0] latch_out;
    logic [3:0] digit_out;
    int         error_cnt      = 0;
    int         checked        = 0;
    int         cyc            = 0;
    bit         run            = 1'b0;
    note_type   notes[$];
    note_type   n;
    logic [5:0] p;
    logic [5:0] d;
    logic [3:0] pn;
    logic [3:0] n1;
    logic [3:0] n2;
    logic [7:0] prog [25];
    logic [9:0] far_a [8] = '{10'h090, 10'h085, 10'h098, 10'h0A0,
                              10'h0A8, 10'h0A1, 10'h099, 10'h086};
    logic [7:0] far_d [8] = '{8'hC5, 8'h98, 8'hA0, 8'hA8,
                              8'h01, 8'h01, 8'h01, 8'h01};
    string      nm [5]    = '{"program_counter", "ram_pointer",
                              "accumulator", "latch_out", "digit_out"};

    // Free-running instruction clock.
    always #25 mclk = ~mclk;

    mcu_sequencer mcu_sequencer_i
    (
        .mclk            (mclk),
        .reset           (reset),
        .rom_load_en     (rom_load_en),
        .rom_load_addr   (rom_load_addr),
        .rom_load_data   (rom_load_data),
        .port_nibble_in  (port_nibble_in),
        .program_counter (program_counter),
        .ram_pointer     (ram_pointer),
        .accumulator     (accumulator),
        .latch_out       (latch_out),
        .digit_out       (digit_out)
    );

    // Compares one seen value against its expectation.
    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Records an expected output value after a given instruction count.
    task automatic note(int c, int s, logic [9:0] v);
        notes.push_back('{c, s, v});
    endtask

    // Writes one program word; called just after a falling edge.
    task automatic put(logic [9:0] a, logic [7:0] v);
        rom_load_en = 1'b1;
        rom_load_addr = a;
        rom_load_data = v;
        @(negedge mclk);
    endtask

    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Selects the output named by a note.
    function automatic logic [9:0] pick(int s);
        case (s)
            0: return program_counter;
            1: return {4'h0, ram_pointer};
            2: return {6'h00, accumulator};
            3: return {2'h0, latch_out};
            default: return {6'h00, digit_out};
        endcase
    endfunction

    // Counts cycles from the first release of reset, later reset cycles included, and checks every note that falls due.
    always @(negedge mclk)
    begin
        if (run)
        begin
            cyc++;
            while (notes.size() > 0 && notes[0].cyc == cyc)
            begin
                n = notes.pop_front();
                check(nm[n.sel], pick(n.sel), n.val);
            end
        end
    end

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        #150000;
        error_cnt++;
        finish_test();
    end

    // Loads the program under reset, releases it, then resets again.
    initial
    begin
        void'($urandom(32'h4F95));
        p = 6'($urandom());
        d = p ^ 6'h30;
        pn = 4'($urandom());
        n1 = pn ^ 4'h8;
        n2 = n1 ^ 4'h3;
        port_nibble_in = pn;
        prog = '{8'h22, {2'h0, p}, {4'h1, n1}, 8'h05, {4'h1, n2}, 8'h04,
                 {4'h1, n2}, 8'h06, 8'h04, 8'h07, 8'h08, 8'h0A, 8'h04,
                 {4'h1, n1}, 8'h21, {2'h0, d}, 8'h20, {2'h0, d}, 8'h22,
                 {2'h0, d}, 8'h04, 8'h10, 8'h0C, 8'h1F, 8'h90};
        @(negedge mclk);
        for (int i = 0; i < 25; i++)
            put(10'(i), prog[i]);
        for (int i = 0; i < 8; i++)
            put(far_a[i], far_d[i]);
        rom_load_en = 1'b0;
        note(2, 1, {4'h0, p});
        note(2, 0, 10'h002);
        note(3, 2, {6'h00, n1});
        note(6, 2, {6'h00, n1});
        note(8, 2, {6'h00, n1});
        note(9, 2, {6'h00, n2});
        note(10, 4, {6'h00, p[3:0]});
        note(11, 3, {2'h0, n2, n2});
        note(13, 2, {6'h00, pn});
        note(18, 2, {6'h00, n1});
        note(20, 1, {4'h0, d});
        note(21, 2, {6'h00, n1});
        note(24, 2, 10'h000);
        note(24, 0, 10'h018);
        note(25, 0, 10'h090);
        note(26, 0, 10'h085);
        note(29, 0, 10'h0A8);
        note(30, 0, 10'h0A1);
        note(31, 0, 10'h099);
        note(32, 0, 10'h086);
        note(33, 0, 10'h086);
        note(34, 0, mcu_seq_pkg::PC_RESET);
        note(34, 1, {4'h0, mcu_seq_pkg::POINTER_RESET});
        note(34, 2, {6'h00, mcu_seq_pkg::NIBBLE_RESET});
        note(34, 3, {2'h0, mcu_seq_pkg::LATCH_RESET});
        note(34, 4, {6'h00, mcu_seq_pkg::NIBBLE_RESET});
        note(37, 0, 10'h001);
        note(38, 3, {2'h0, 8'h09});
        note(39, 0, 10'h009);
        repeat (8) @(negedge mclk);
        reset <= 1'b0;
        run <= 1'b1;
        repeat (33) @(negedge mclk);
        reset <= 1'b1;
        // Under reset, replace the first words to reach both indirects.
        put(10'h000, 8'h09);
        put(10'h001, 8'h03);
        put(10'h002, 8'h02);
        rom_load_en = 1'b0;
        reset <= 1'b0;
        for (int i = 0; i < 100 && notes.size() > 0; i++)
            @(negedge mclk);
        if (notes.size() > 0)
            error_cnt++;
        finish_test();
    end
endmodule // mcu_rom_sequencer_ram_addressing_test

bind mcu_sequencer mcu_sequencer_props mcu_sequencer_props_i
(
    .mclk, .reset, .rom_load_en, .rom_load_addr, .rom_load_data,
    .port_nibble_in, .program_counter, .ram_pointer, .accumulator,
    .latch_out, .digit_out
);

// [verification/mcu_sequencer_props.sv]
// Concurrent checks on the ports of the sequencer core.
// Assumes the program store is loaded only through its write port.
module mcu_sequencer_props
(
    // Clock and reset.
    input wire logic       mclk,
    input wire logic       reset,
    // Program store loading and port lines.
    input wire logic       rom_load_en,
    input wire logic [9:0] rom_load_addr,
    input wire logic [7:0] rom_load_data,
    input wire logic [3:0] port_nibble_in,
    // Registered state.
    input wire logic [9:0] program_counter,
    input wire logic [5:0] ram_pointer,
    input wire logic [3:0] accumulator,
    input wire logic [7:0] latch_out,
    input wire logic [3:0] digit_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // Shadow store; kind: 0 fetch, 1 operand, 2 skipped, 3 skipped operand.
    logic [7:0] rom_sh [0:1023];
    logic [1:0] kind_reg;
    logic [1:0] kind_next;
    logic [7:0] w;
    logic       seq_w;
    assign w = rom_sh[program_counter];
    assign seq_w = w < 8'h80 && w != 8'h01 && w != 8'h02 && w[7:4] != 4'h2;

    // Works out whether the next word executes, is an operand or is skipped.
    always_comb
    begin
        kind_next = 2'h0;
        if (kind_reg == 2'h0 && w[7:4] == 4'h2)
            kind_next = 2'h1;
        else if (kind_reg == 2'h0 && ((w == 8'h0C && accumulator == 4'h0)
                 || (w == 8'h0B && ram_pointer[3:0] == 4'hF)))
            kind_next = 2'h2;
        else if (kind_reg == 2'h2 && w[7:4] == 4'h2)
            kind_next = 2'h3;
    end

    // Registers the shadow store and the word kind.
    always_ff @(posedge mclk)
    begin
        if (rom_load_en)
            rom_sh[rom_load_addr] <= rom_load_data;
        kind_reg <= reset ? 2'h0 : kind_next;
    end

    sequence s_call;
        kind_reg == 2'h0 && w[7:6] == 2'b10;
    endsequence
    sequence s_ret;
        kind_reg == 2'h0 && w == mcu_seq_pkg::OP_RETURN;
    endsequence
    sequence s_store_reload;
        kind_reg == 2'h0 && w == 8'h05 ##1 kind_reg == 2'h0 && w[7:4] == 4'h1
            ##1 kind_reg == 2'h0 && w == 8'h04;
    endsequence
    sequence s_direct_pair;
        kind_reg == 2'h0 && w == 8'h21 ##1 kind_reg == 2'h1
            ##1 kind_reg == 2'h0 && w == 8'h20
            ##1 kind_reg == 2'h1 && w == $past(w, 2);
    endsequence

    property p_pc_step;
        kind_reg[1] || (kind_reg == 2'h0 && seq_w)
            |=> program_counter == $past(program_counter) + 10'h001;
    endproperty
    property p_page_jump;
        kind_reg == 2'h0 && w[7:6] == 2'b11
            |=> program_counter == {$past(program_counter[9:6]), $past(w[5:0])};
    endproperty
    property p_call_target;
        s_call |=> program_counter == {mcu_seq_pkg::CALL_PAGE, $past(w[5:0])};
    endproperty
    property p_call_return;
        s_call ##1 s_ret
            |=> program_counter == $past(program_counter, 2) + 10'h001;
    endproperty
    property p_ptr_load;
        kind_reg == 2'h0 && w == 8'h22 ##1 kind_reg == 2'h1
            |=> ram_pointer == $past(w[5:0]);
    endproperty
    property p_digit_out;
        kind_reg == 2'h0 && w == 8'h07
            |=> digit_out == $past(ram_pointer[3:0]);
    endproperty
    property p_acc_imm;
        kind_reg == 2'h0 && w[7:4] == 4'h1 |=> accumulator == $past(w[3:0]);
    endproperty
    property p_store_reload;
        s_store_reload |=> accumulator == $past(accumulator, 3);
    endproperty
    property p_direct_ram;
        s_direct_pair |=> accumulator == $past(accumulator, 4);
    endproperty
    property p_skip_hold;
        kind_reg == 2'h2 && w[7:4] == 4'h1 |=> $stable(accumulator);
    endproperty

    a_pc_step: assert property (p_pc_step)
        else $error("Program counter did not advance by one.");
    a_page_jump: assert property (p_page_jump)
        else $error("Page jump left its page or missed its target.");
    a_call_target: assert property (p_call_target)
        else $error("Page call did not enter the call page.");
    a_call_return: assert property (p_call_return)
        else $error("Return did not resume after the call.");
    a_ptr_load: assert property (p_ptr_load)
        else $error("Pointer does not hold the loaded operand.");
    a_digit_out: assert property (p_digit_out)
        else $error("Digit outputs differ from the digit field.");
    a_acc_imm: assert property (p_acc_imm)
        else $error("Accumulator missed its immediate value.");
    a_store_reload: assert property (p_store_reload)
        else $error("Stored digit did not read back.");
    a_direct_ram: assert property (p_direct_ram)
        else $error("Direct digit did not read back.");
    a_skip_hold: assert property (p_skip_hold)
        else $error("Skipped word changed the accumulator.");
endmodule // mcu_sequencer_props
